// *** logic/ptrr_defs.vh ***
// Purpose: shared constants for the timestamp readout register bank
// Assumes: 16-bit management registers, 5-bit register address, one clock
// Notes:   included by every design file of the block
`ifndef PTRR_DEFS_VH
`define PTRR_DEFS_VH

`define PTRR_DW          16
`define PTRR_NS_W        30
`define PTRR_SEC_W       32
`define PTRR_UNITS       8
`define PTRR_ADDR_W      5

`define PTRR_ADDR_RDSUM  5'h1A
`define PTRR_ADDR_WRSUM  5'h1B
`define PTRR_ADDR_TXTS   5'h1C
`define PTRR_ADDR_RXTS   5'h1D
`define PTRR_ADDR_ESTS   5'h1E
`define PTRR_ADDR_EDATA  5'h1F

`define PTRR_W0          3'h0
`define PTRR_W1          3'h1
`define PTRR_W2          3'h2
`define PTRR_W3          3'h3
`define PTRR_W4          3'h4
`define PTRR_W5          3'h5
`define PTRR_TX_LAST     3'h3
`define PTRR_RX_LAST     3'h5
`define PTRR_EV_LAST     3'h4

`define PTRR_LEN_1       2'h0
`define PTRR_LEN_2       2'h1
`define PTRR_LEN_3       2'h2
`define PTRR_LEN_4       2'h3

`define PTRR_ZERO16      16'h0000
`define PTRR_NS_PAD      2'h0
`define PTRR_ST_RSVD     5'h00
`define PTRR_DROP_MAX    2'h3
`define PTRR_MISS_MAX    3'h7

`define PTRR_QDEPTH      4
`define PTRR_QPTR_W      2
`define PTRR_QCNT_W      3

`endif

// *** logic/ptrr_stamp_queue.v ***
// Purpose: small stamp queue with a saturating count of dropped pushes
// Assumes: push and pop come from logic on sys_clk
// Notes:   the drop count rides with the next stamp that is accepted
`include "ptrr_defs.vh"

module ptrr_stamp_queue #(
   parameter DATA_W = 62
) (
   // clock and reset
   input  wire                sys_clk,
   input  wire                resetn,
   // fill side
   input  wire                push,
   input  wire [DATA_W-1:0]   pushData,
   output wire                dropPulse,
   // drain side
   input  wire                pop,
   output wire [DATA_W-1:0]   headData,
   output wire [1:0]          headDrop,
   output wire                empty,
   output wire                full
);
   reg  [DATA_W+1:0]          mem [0:`PTRR_QDEPTH-1];
   reg  [`PTRR_QPTR_W-1:0]    wrPtr_reg;
   reg  [`PTRR_QPTR_W-1:0]    rdPtr_reg;
   reg  [`PTRR_QCNT_W-1:0]    count_reg;
   reg  [1:0]                 drop_reg;
   wire                       doPop;
   wire                       doPush;

   assign empty     = (count_reg == {`PTRR_QCNT_W{1'b0}});
   assign full      = (count_reg == `PTRR_QDEPTH);
   assign doPop     = pop & ~empty;
   // a pop in the same cycle frees the slot, so a full queue still accepts
   assign doPush    = push & (~full | doPop);
   assign dropPulse = push & ~doPush;
   assign {headDrop, headData} = mem[rdPtr_reg];

   always @(posedge sys_clk) begin
      if (!resetn) begin
         wrPtr_reg <= {`PTRR_QPTR_W{1'b0}};
         rdPtr_reg <= {`PTRR_QPTR_W{1'b0}};
         count_reg <= {`PTRR_QCNT_W{1'b0}};
         drop_reg  <= 2'h0;
      end else begin
         if (doPush) begin
            mem[wrPtr_reg] <= {drop_reg, pushData};
            wrPtr_reg      <= wrPtr_reg + 1'b1;
            drop_reg       <= 2'h0;
         end else if (dropPulse && drop_reg != `PTRR_DROP_MAX) begin
            drop_reg <= drop_reg + 1'b1;
         end
         if (doPop)
            rdPtr_reg <= rdPtr_reg + 1'b1;
         if (doPush && !doPop)
            count_reg <= count_reg + 1'b1;
         else if (doPop && !doPush)
            count_reg <= count_reg - 1'b1;
      end
   end
endmodule // ptrr_stamp_queue

// *** logic/ptrr_regs.v ***
// Purpose: page 4 write sum and queued transmit, receive and event readouts
// Assumes: a management front end delivers one-cycle read and write strobes
// Notes:   read data appears one cycle after the read strobe, with a valid pulse
`include "ptrr_defs.vh"

module ptrr_regs (
   // clock and reset
   input  wire                     sys_clk,
   input  wire                     resetn,
   // register access from management or control frames
   input  wire                     regWrite,
   input  wire                     regRead,
   input  wire [`PTRR_ADDR_W-1:0]  regAddr,
   input  wire [`PTRR_DW-1:0]      regWrData,
   input  wire                     page4Sel,
   input  wire                     viaCtrlFrame,
   output reg  [`PTRR_DW-1:0]      regRdData,
   output reg                      regRdValid,
   // link to the read sum accumulator
   output reg                      readSumAdd,
   output reg  [`PTRR_DW-1:0]      readSumAddData,
   // transmit stamp engine
   input  wire                     txStampPush,
   input  wire [`PTRR_NS_W-1:0]    txStampNs,
   input  wire [`PTRR_SEC_W-1:0]   txStampSec,
   // receive stamp engine
   input  wire                     rxStampPush,
   input  wire [`PTRR_NS_W-1:0]    rxStampNs,
   input  wire [`PTRR_SEC_W-1:0]   rxStampSec,
   input  wire [15:0]              rxSeqId,
   input  wire [3:0]               rxMsgType,
   input  wire [11:0]              rxSrcHash,
   // event capture units
   input  wire                     evtCapture,
   input  wire [`PTRR_UNITS-1:0]   evtDetMask,
   input  wire [`PTRR_UNITS-1:0]   evtRiseMask,
   input  wire [`PTRR_NS_W-1:0]    evtNs,
   input  wire [`PTRR_SEC_W-1:0]   evtSec,
   // status
   output wire                     capturePresent
);
   function [`PTRR_DW-1:0] onesAdd;
      input [`PTRR_DW-1:0] a;
      input [`PTRR_DW-1:0] b;
      reg   [`PTRR_DW:0]   s;
      begin
         s       = {1'b0, a} + {1'b0, b};
         onesAdd = s[`PTRR_DW-1:0] + {{(`PTRR_DW-1){1'b0}}, s[`PTRR_DW]};
      end
   endfunction

   function [2:0] lowestSet;
      input [`PTRR_UNITS-1:0] v;
      integer i;
      begin
         lowestSet = 3'h0;
         for (i = `PTRR_UNITS - 1; i >= 0; i = i - 1)
            if (v[i])
               lowestSet = i[2:0];
      end
   endfunction

   // access decode
   wire       p4Rd   = regRead & page4Sel;
   wire       p4Wr   = regWrite & page4Sel;
   wire       mgmtWr = p4Wr & ~viaCtrlFrame;
   wire       rdWrSum = p4Rd && regAddr == `PTRR_ADDR_WRSUM;
   wire       rdTx    = p4Rd && regAddr == `PTRR_ADDR_TXTS;
   wire       rdRx    = p4Rd && regAddr == `PTRR_ADDR_RXTS;
   wire       rdSts   = p4Rd && regAddr == `PTRR_ADDR_ESTS;
   wire       rdData  = p4Rd && regAddr == `PTRR_ADDR_EDATA;

   // write sum
   reg  [`PTRR_DW-1:0] writeSum_reg;

   always @(posedge sys_clk) begin
      if (!resetn) begin
         writeSum_reg   <= `PTRR_ZERO16;
         readSumAdd     <= 1'b0;
         readSumAddData <= `PTRR_ZERO16;
      end else begin
         if (rdWrSum)
            writeSum_reg <= `PTRR_ZERO16;
         else if (mgmtWr)
            writeSum_reg <= onesAdd(writeSum_reg, regWrData);
         readSumAdd <= rdWrSum & ~viaCtrlFrame;
         if (rdWrSum)
            readSumAddData <= writeSum_reg;
      end
   end

   // transmit queue
   wire [`PTRR_NS_W-1:0]  txNs;
   wire [`PTRR_SEC_W-1:0] txSec;
   wire [1:0]             txDrop;
   wire                   txEmpty;
   reg  [2:0]             txIdx_reg;
   wire                   txPop = rdTx & ~txEmpty & (txIdx_reg == `PTRR_TX_LAST);

   ptrr_stamp_queue #(
      .DATA_W(`PTRR_NS_W + `PTRR_SEC_W)
   ) txQueue (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .push      (txStampPush),
      .pushData  ({txStampNs, txStampSec}),
      .dropPulse (),
      .pop       (txPop),
      .headData  ({txNs, txSec}),
      .headDrop  (txDrop),
      .empty     (txEmpty),
      .full      ()
   );

   // receive queue
   wire [`PTRR_NS_W-1:0]  rxNs;
   wire [`PTRR_SEC_W-1:0] rxSec;
   wire [15:0]            rxSeq;
   wire [3:0]             rxType;
   wire [11:0]            rxHash;
   wire [1:0]             rxDrop;
   wire                   rxEmpty;
   reg  [2:0]             rxIdx_reg;
   wire                   rxPop = rdRx & ~rxEmpty & (rxIdx_reg == `PTRR_RX_LAST);

   ptrr_stamp_queue #(
      .DATA_W(`PTRR_NS_W + `PTRR_SEC_W + 32)
   ) rxQueue (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .push      (rxStampPush),
      .pushData  ({rxStampNs, rxStampSec, rxSeqId, rxMsgType, rxSrcHash}),
      .dropPulse (),
      .pop       (rxPop),
      .headData  ({rxNs, rxSec, rxSeq, rxType, rxHash}),
      .headDrop  (rxDrop),
      .empty     (rxEmpty),
      .full      ()
   );

   // word indexes; an empty queue leaves the index alone so nothing is skipped
   always @(posedge sys_clk) begin
      if (!resetn) begin
         txIdx_reg <= `PTRR_W0;
         rxIdx_reg <= `PTRR_W0;
      end else begin
         if (rdTx && !txEmpty)
            txIdx_reg <= txPop ? `PTRR_W0 : txIdx_reg + 1'b1;
         if (rdRx && !rxEmpty)
            rxIdx_reg <= rxPop ? `PTRR_W0 : rxIdx_reg + 1'b1;
      end
   end

   // event capture: per-unit missed counters
   wire                        evFull;
   wire                        evEmpty;
   wire                        evDrop;
   wire                        evPush = evtCapture & ~evDrop;
   wire [`PTRR_UNITS*3-1:0]    missFlat;
   wire [`PTRR_UNITS-1:0]      missAny;
   wire [`PTRR_UNITS-1:0]      missHit = missAny & evtDetMask;
   wire [2:0]                  newNum;
   reg  [2:0]                  newMiss;
   integer                     k;

   // missed count of the reported unit, chosen below
   always @* begin
      newMiss = 3'h0;
      for (k = 0; k < `PTRR_UNITS; k = k + 1)
         if (newNum == k[2:0])
            newMiss = missFlat[k*3 +: 3];
   end

   // among units that fired, one with misses wins so its loss is not hidden
   assign newNum = (|missHit) ? lowestSet(missHit) : lowestSet(evtDetMask);

   genvar u;
   generate
      for (u = 0; u < `PTRR_UNITS; u = u + 1) begin : gUnit
         reg [2:0] missCnt_reg;
         always @(posedge sys_clk) begin
            if (!resetn)
               missCnt_reg <= 3'h0;
            else if (evDrop && evtDetMask[u] && missCnt_reg != `PTRR_MISS_MAX)
               missCnt_reg <= missCnt_reg + 1'b1;
            else if (evPush && missHit[u] && newNum == u)
               missCnt_reg <= 3'h0;
         end
         assign missFlat[u*3 +: 3] = missCnt_reg;
         assign missAny[u]         = (missCnt_reg != 3'h0);
      end
   endgenerate

   // changed-word length against the previous accepted event
   reg  [4*`PTRR_DW-1:0] prevTs_reg;
   wire [4*`PTRR_DW-1:0] newTs = {evtSec, `PTRR_NS_PAD, evtNs};
   wire [`PTRR_DW-1:0]   nW0, nW1, nW2, nW3, oW0, oW1, oW2, oW3;
   reg  [1:0]            newLen;

   assign {nW3, nW2, nW1, nW0} = newTs;
   assign {oW3, oW2, oW1, oW0} = prevTs_reg;

   always @* begin
      if (nW3 != oW3 || nW2 != oW2)
         newLen = `PTRR_LEN_4;
      else if (nW1 != oW1)
         newLen = `PTRR_LEN_2;
      else
         newLen = `PTRR_LEN_1;
   end

   always @(posedge sys_clk) begin
      if (!resetn)
         prevTs_reg <= {(4*`PTRR_DW){1'b0}};
      else if (evPush)
         prevTs_reg <= newTs;
   end

   wire [8:0]             newMeta = {newMiss, newLen, evtRiseMask[newNum], newNum};
   wire [`PTRR_UNITS-1:0] hDet;
   wire [`PTRR_UNITS-1:0] hRise;
   wire [8:0]             hMeta;
   wire [4*`PTRR_DW-1:0]  hTs;

   ptrr_stamp_queue #(
      .DATA_W(2*`PTRR_UNITS + 9 + 4*`PTRR_DW)
   ) evQueue (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .push      (evtCapture),
      .pushData  ({evtDetMask, evtRiseMask & evtDetMask, newMeta, newTs}),
      .dropPulse (evDrop),
      .pop       (rdSts),
      .headData  ({hDet, hRise, hMeta, hTs}),
      .headDrop  (),
      .empty     (evEmpty),
      .full      (evFull)
   );

   // head status and extended word
   wire                  hMult = (hDet & (hDet - 1'b1)) != {`PTRR_UNITS{1'b0}};
   wire                  hAny  = |hDet;
   wire [`PTRR_DW-1:0]   hStatus = evEmpty ? `PTRR_ZERO16 :
                                   {`PTRR_ST_RSVD, hMeta, hMult, hAny};
   wire [`PTRR_DW-1:0]   hExt;

   generate
      for (u = 0; u < `PTRR_UNITS; u = u + 1) begin : gExt
         assign hExt[2*u]   = hDet[u];
         assign hExt[2*u+1] = hRise[u];
      end
   endgenerate

   // presented event, loaded by each status read
   reg  [`PTRR_DW-1:0]   presStatus_reg;
   reg  [`PTRR_DW-1:0]   presExt_reg;
   reg  [4*`PTRR_DW-1:0] presTs_reg;
   reg  [2:0]            evIdx_reg;
   wire [`PTRR_DW-1:0]   pW0, pW1, pW2, pW3;
   wire                  presMult = presStatus_reg[1];
   wire [2:0]            evFirst  = presMult ? `PTRR_W0 : `PTRR_W1;

   assign {pW3, pW2, pW1, pW0} = presTs_reg;
   assign capturePresent       = presStatus_reg[0];

   always @(posedge sys_clk) begin
      if (!resetn) begin
         presStatus_reg <= `PTRR_ZERO16;
         presExt_reg    <= `PTRR_ZERO16;
         presTs_reg     <= {(4*`PTRR_DW){1'b0}};
         evIdx_reg      <= `PTRR_W1;
      end else if (rdSts) begin
         presStatus_reg <= hStatus;
         presExt_reg    <= evEmpty ? `PTRR_ZERO16 : hExt;
         presTs_reg     <= evEmpty ? {(4*`PTRR_DW){1'b0}} : hTs;
         evIdx_reg      <= (hMult && !evEmpty) ? `PTRR_W0 : `PTRR_W1;
      end else if (rdData && capturePresent) begin
         evIdx_reg <= (evIdx_reg == `PTRR_EV_LAST) ? evFirst : evIdx_reg + 1'b1;
      end
   end

   // read data selection
   reg [`PTRR_DW-1:0] rdNext;

   always @* begin
      rdNext = `PTRR_ZERO16;
      case (regAddr)
         `PTRR_ADDR_WRSUM: rdNext = writeSum_reg;
         `PTRR_ADDR_TXTS: begin
            if (!txEmpty) begin
               case (txIdx_reg)
                  `PTRR_W0: rdNext = txNs[15:0];
                  `PTRR_W1: rdNext = {txDrop, txNs[29:16]};
                  `PTRR_W2: rdNext = txSec[15:0];
                  `PTRR_W3: rdNext = txSec[31:16];
                  default:  rdNext = `PTRR_ZERO16;
               endcase
            end
         end
         `PTRR_ADDR_RXTS: begin
            if (!rxEmpty) begin
               case (rxIdx_reg)
                  `PTRR_W0: rdNext = rxNs[15:0];
                  `PTRR_W1: rdNext = {rxDrop, rxNs[29:16]};
                  `PTRR_W2: rdNext = rxSec[15:0];
                  `PTRR_W3: rdNext = rxSec[31:16];
                  `PTRR_W4: rdNext = rxSeq;
                  `PTRR_W5: rdNext = {rxType, rxHash};
                  default:  rdNext = `PTRR_ZERO16;
               endcase
            end
         end
         `PTRR_ADDR_ESTS: rdNext = hStatus;
         `PTRR_ADDR_EDATA: begin
            if (capturePresent) begin
               case (evIdx_reg)
                  `PTRR_W0: rdNext = presExt_reg;
                  `PTRR_W1: rdNext = pW0;
                  `PTRR_W2: rdNext = pW1;
                  `PTRR_W3: rdNext = pW2;
                  `PTRR_W4: rdNext = pW3;
                  default:  rdNext = `PTRR_ZERO16;
               endcase
            end else begin
               rdNext = `PTRR_ZERO16;
            end
         end
         default: rdNext = `PTRR_ZERO16;
      endcase
   end

   // answer only for page 4 reads of this bank; other addresses read zero
   always @(posedge sys_clk) begin
      if (!resetn) begin
         regRdData  <= `PTRR_ZERO16;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= p4Rd;
         if (p4Rd)
            regRdData <= rdNext;
      end
   end

   // evFull only matters through the queue's drop pulse
   wire unusedFull = evFull;
endmodule // ptrr_regs

// *** tb/ptrr_regs_props.sv ***
// Purpose: port-level checks for the timestamp readout bank
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to ptrr_regs from tb_top
module ptrr_regs_props (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        resetn,
   // register access
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [4:0]  regAddr,
   input wire logic        page4Sel,
   input wire logic        viaCtrlFrame,
   // answers
   input wire logic [15:0] regRdData,
   input wire logic        regRdValid,
   input wire logic        readSumAdd,
   input wire logic [15:0] readSumAddData,
   input wire logic        capturePresent
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   wire logic rdAny = regRead && page4Sel;
   wire logic rdSum = rdAny && regAddr == 5'h1B;
   wire logic rdSts = rdAny && regAddr == 5'h1E;

   chk_read_answer: assert property (rdAny |=> regRdValid)
      else $error("page read got no answer");
   chk_answer_cause: assert property (regRdValid |-> $past(rdAny))
      else $error("answer without a read");
   chk_sum_feed: assert property ((rdSum && !viaCtrlFrame) |=>
      readSumAdd && readSumAddData == regRdData)
      else $error("returned write sum not fed to read sum");
   chk_frame_nofeed: assert property (readSumAdd |-> $past(rdSum && !viaCtrlFrame))
      else $error("read sum fed without a management sum read");
   chk_sum_clear: assert property (rdSum ##1 !regWrite ##1 rdSum |=>
      regRdData == 16'h0000)
      else $error("write sum not cleared by read");
   chk_status_rsvd: assert property (rdSts |=> regRdData[15:11] == 5'h00)
      else $error("reserved status bits not zero");
   chk_present_bit: assert property (rdSts |=> capturePresent == regRdData[0])
      else $error("present flag disagrees with status");
   chk_status_zero: assert property (rdSts |=>
      (regRdData[0] || regRdData == 16'h0000))
      else $error("status fields set with no event");
endmodule // ptrr_regs_props

// *** tb/ptrr_host_model.sv ***
// Purpose: management host issuing page reads and writes
// Assumes: strobes last one cycle, answer one cycle after the read
// Notes:   released address and data lines show inverted garbage
module ptrr_host_model (
   // clock
   input wire logic         sys_clk,
   // answer from the bank
   input wire logic         regRdValid,
   input wire logic [15:0]  regRdData,
   // strobes to the bank
   output logic             regWrite,
   output logic             regRead,
   output logic [4:0]       regAddr,
   output logic [15:0]      regWrData,
   output logic             page4Sel,
   output logic             viaCtrlFrame
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      regWrite = 1'h0;
      regRead = 1'h0;
      regAddr = 5'h00;
      regWrData = 16'h0000;
      page4Sel = 1'h1;
      viaCtrlFrame = 1'h0;
   end
   // only a status read moves the event queue on
   task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
                      input logic cf, input logic p4, output logic [15:0] q);
      @(posedge sys_clk);
      #2;
      regWrite = w;
      regRead = !w;
      regAddr = a;
      regWrData = d;
      viaCtrlFrame = cf;
      page4Sel = p4;
      @(posedge sys_clk);
      #2;
      regWrite = 1'h0;
      regRead = 1'h0;
      regAddr = ~a;
      regWrData = ~d;
      q = regRdValid ? regRdData : 16'hXXXX;
   endtask
endmodule // ptrr_host_model

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the timestamp readout bank
// Assumes: queue depth 4, read answer one cycle after the strobe
// Notes:   stamp and event sources are driven directly by the bench
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'h0;
   logic resetn = 1'h0;
   wire logic regWrite, regRead, page4Sel, viaCtrlFrame, regRdValid, readSumAdd;
   wire logic capturePresent;
   wire logic [4:0] regAddr;
   wire logic [15:0] regWrData, regRdData, readSumAddData;
   logic txPush = '0, rxPush = '0, evCap = '0;
   logic [29:0] txNs = '0, rxNs = '0, evNs = '0;
   logic [31:0] txSec = '0, rxSec = '0, evSec = '0;
   logic [15:0] rxSeq = '0;
   logic [3:0] rxType = '0;
   logic [11:0] rxHash = '0;
   logic [7:0] evDet = '0, evRise = '0;
   int nMismatch = 0;
   int totalChecks = 0;

   always #25 sys_clk = ~sys_clk;

   ptrr_regs u_ptrr_regs (.sys_clk(sys_clk), .resetn(resetn), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .page4Sel(page4Sel),
      .viaCtrlFrame(viaCtrlFrame), .regRdData(regRdData), .regRdValid(regRdValid),
      .readSumAdd(readSumAdd), .readSumAddData(readSumAddData), .txStampPush(txPush),
      .txStampNs(txNs), .txStampSec(txSec), .rxStampPush(rxPush), .rxStampNs(rxNs),
      .rxStampSec(rxSec), .rxSeqId(rxSeq), .rxMsgType(rxType), .rxSrcHash(rxHash),
      .evtCapture(evCap), .evtDetMask(evDet), .evtRiseMask(evRise), .evtNs(evNs),
      .evtSec(evSec), .capturePresent(capturePresent));
   ptrr_host_model u_ptrr_host_model (.sys_clk(sys_clk), .regRdValid(regRdValid),
      .regRdData(regRdData), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
      .regWrData(regWrData), .page4Sel(page4Sel), .viaCtrlFrame(viaCtrlFrame));

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      totalChecks++;
      if (g !== e) begin
         nMismatch++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rc(input logic [4:0] a, input logic [15:0] e, input string n);
      logic [15:0] q;
      u_ptrr_host_model.acc(1'h0, a, 16'h0000, 1'h0, 1'h1, q);
      chk(n, e, q);
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic cf,
                     input logic p4);
      logic [15:0] q;
      u_ptrr_host_model.acc(1'h1, a, d, cf, p4, q);
   endtask
   // end-around carry add
   function automatic logic [15:0] oc(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {1'h0, a} + {1'h0, b};
      return s[15:0] + {15'h0000, s[16]};
   endfunction
   task automatic pushTx(input logic [29:0] n, input logic [31:0] s);
      @(posedge sys_clk);
      #2;
      txPush = 1'h1;
      txNs = n;
      txSec = s;
      @(posedge sys_clk);
      #2;
      txPush = 1'h0;
   endtask
   task automatic cap(input logic [7:0] d, input logic [7:0] r, input logic [29:0] n,
                      input logic [31:0] s);
      @(posedge sys_clk);
      #2;
      evCap = 1'h1;
      evDet = d;
      evRise = r;
      evNs = n;
      evSec = s;
      @(posedge sys_clk);
      #2;
      evCap = 1'h0;
   endtask
   task automatic rdStamp(input logic [4:0] a, input logic [29:0] n,
                          input logic [31:0] s, input logic [1:0] dr);
      rc(a, n[15:0], "ns low");
      rc(a, {dr, n[29:16]}, "drop and ns high");
      rc(a, s[15:0], "sec low");
      rc(a, s[31:16], "sec high");
   endtask

   task automatic t_reset;
      rc(5'h1C, 16'h0000, "tx after reset");
      rc(5'h1D, 16'h0000, "rx after reset");
      rc(5'h1E, 16'h0000, "status after reset");
      rc(5'h1F, 16'h0000, "data after reset");
      chk("present after reset", 16'h0000, {15'h0000, capturePresent});
   endtask
   task automatic t_wsum;
      logic [15:0] e;
      logic [15:0] q;
      e = oc(oc(oc(oc(16'hFFF0, 16'h0020), 16'h0001), 16'h0100), 16'hF800);
      wr(5'h10, 16'hFFF0, 1'h0, 1'h1);
      wr(5'h11, 16'h0020, 1'h0, 1'h1);
      wr(5'h1B, 16'h0001, 1'h0, 1'h1);
      wr(5'h1A, 16'h0100, 1'h0, 1'h1);
      wr(5'h1E, 16'hF800, 1'h0, 1'h1);
      wr(5'h12, 16'h1234, 1'h1, 1'h1);
      wr(5'h13, 16'h4321, 1'h0, 1'h0);
      rc(5'h1E, 16'h0000, "status after write");
      rc(5'h1B, e, "write sum");
      rc(5'h1B, 16'h0000, "sum after read");
      wr(5'h14, 16'h0005, 1'h0, 1'h1);
      u_ptrr_host_model.acc(1'h0, 5'h1B, 16'h0000, 1'h1, 1'h1, q);
      chk("sum by frame", 16'h0005, q);
      rc(5'h1B, 16'h0000, "sum after frame read");
   endtask
   task automatic t_tx;
      pushTx(30'h2ABC1234, 32'h89ABCDEF);
      pushTx(30'h0000FFFF, 32'h00000001);
      rdStamp(5'h1C, 30'h2ABC1234, 32'h89ABCDEF, 2'h0);
      rdStamp(5'h1C, 30'h0000FFFF, 32'h00000001, 2'h0);
      rc(5'h1C, 16'h0000, "tx empty");
      // eight pushes into four slots: four drops
      for (int i = 0; i < 8; i++) pushTx(30'h00100000 + 30'(i), 32'h00020000 + 32'(i));
      for (int i = 0; i < 4; i++)
         rdStamp(5'h1C, 30'h00100000 + 30'(i), 32'h00020000 + 32'(i), 2'h0);
      pushTx(30'h3FFFFFFF, 32'hFFFFFFFF);
      rdStamp(5'h1C, 30'h3FFFFFFF, 32'hFFFFFFFF, 2'h3);
   endtask
   task automatic t_rx;
      @(posedge sys_clk);
      #2;
      rxPush = 1'h1;
      rxNs = 30'h15555555;
      rxSec = 32'h13572468;
      rxSeq = 16'hBEEF;
      rxType = 4'hA;
      rxHash = 12'h5C3;
      @(posedge sys_clk);
      #2;
      rxPush = 1'h0;
      rdStamp(5'h1D, 30'h15555555, 32'h13572468, 2'h0);
      rc(5'h1D, 16'hBEEF, "rx sequence");
      rc(5'h1D, 16'hA5C3, "rx type and hash");
      rc(5'h1D, 16'h0000, "rx empty");
   endtask
   task automatic t_evt;
      cap(8'h01, 8'h01, 30'h2FED0123, 32'h00000010);
      cap(8'h0A, 8'h08, 30'h2FED0456, 32'h00000010);
      rc(5'h1E, 16'h00E1, "first status");
      chk("present flag", 16'h0001, {15'h0000, capturePresent});
      rc(5'h1F, 16'h0123, "event ns low");
      rc(5'h1F, 16'h2FED, "event ns high");
      rc(5'h1F, 16'h0010, "event sec low");
      rc(5'h1F, 16'h0000, "event sec high");
      rc(5'h1E, 16'h0007, "second status");
      rc(5'h1F, 16'h00C4, "extended word");
      rc(5'h1F, 16'h0456, "second ns low");
      rc(5'h1E, 16'h0000, "drained status");
      rc(5'h1F, 16'h0000, "no event data");
      chk("present cleared", 16'h0000, {15'h0000, capturePresent});
   endtask
   task automatic t_miss;
      // six captures into four slots: units 4 and 5 miss two each
      for (int i = 0; i < 6; i++) cap(8'h30, 8'h10, 30'h00000100, 32'h00000020);
      for (int i = 0; i < 4; i++)
         rc(5'h1E, (i == 0) ? 16'h00F3 : 16'h0033, "queued status");
      cap(8'h30, 8'h10, 30'h00000100, 32'h00000020);
      rc(5'h1E, 16'h0233, "status with misses");
      // unit 5 still owes two misses but did not fire here
      cap(8'h01, 8'h00, 30'h00000100, 32'h00000020);
      rc(5'h1E, 16'h0001, "status other unit");
      cap(8'h20, 8'h20, 30'h00000100, 32'h00000020);
      rc(5'h1E, 16'h0235, "status unit five misses");
   endtask
   task automatic t_rst;
      pushTx(30'h01234567, 32'h00C0FFEE);
      rc(5'h1C, 16'h4567, "tx word before reset");
      @(posedge sys_clk);
      #2;
      resetn = 1'h0;
      repeat (2) @(posedge sys_clk);
      #2;
      resetn = 1'h1;
      rc(5'h1C, 16'h0000, "tx emptied by reset");
      pushTx(30'h00ABCDEF, 32'h00000042);
      rdStamp(5'h1C, 30'h00ABCDEF, 32'h00000042, 2'h0);
   endtask

   task automatic giveVerdict;
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge sys_clk);
      #2;
      resetn = 1'h1;
      t_reset;
      t_wsum;
      t_tx;
      t_rx;
      t_evt;
      t_miss;
      t_rst;
      giveVerdict;
   end
   // whole sequence needs well under a thousand cycles
   initial begin
      repeat (4000) @(posedge sys_clk);
      nMismatch++;
      $display("watchdog expired");
      giveVerdict;
   end
endmodule // tb_top

bind ptrr_regs ptrr_regs_props u_ptrr_regs_props (.sys_clk(sys_clk), .resetn(resetn),
   .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .page4Sel(page4Sel),
   .viaCtrlFrame(viaCtrlFrame), .regRdData(regRdData), .regRdValid(regRdValid),
   .readSumAdd(readSumAdd), .readSumAddData(readSumAddData),
   .capturePresent(capturePresent));
